// ### src/rpf_map.svh
// Register map, field positions, reset values and timing counts.
`ifndef RPF_MAP_SVH
`define RPF_MAP_SVH
// Register offsets and reset values.
`define RPF_PIN_IO_ADDR   8'h27
`define RPF_FUNC_ADDR     8'h28
`define RPF_PIN_IO_RESET  8'h00
`define RPF_FUNC_RESET    8'h00
`define RPF_UNMAPPED_READ 8'h00
// Field positions of pin_io_config.
`define RPF_IRQA_FN_LSB   0
`define RPF_EVT_FN_LSB    2
`define RPF_EVT_TYPE_BIT  4
`define RPF_EVT_POL_BIT   5
`define RPF_PULL_BIT      6
`define RPF_CLKPIN_BIT    7
// Field positions of chip_function_config.
`define RPF_COF_LSB       0
`define RPF_STOP_SRC_BIT  3
`define RPF_MODE_BIT      4
`define RPF_PI_LSB        5
`define RPF_HUND_BIT      7
// Clock output codes.
`define RPF_COF_1HZ       3'h6
`define RPF_COF_OFF       3'h7
// Timing: system clock period and prescaler divider to 65.536 kHz.
`define RPF_CLK_NS        8
`define RPF_OSC_DIV       1907
`define RPF_PRESC_W       16
`define RPF_SAMPLE_NS     30500
`define RPF_SAMPLE_CYC    ((`RPF_SAMPLE_NS + `RPF_CLK_NS - 1) / `RPF_CLK_NS)
// Hundredths divider pattern.
`define RPF_DIV3_PERIODS  14
`define RPF_DIV2_PERIODS  11
`define RPF_BLOCK_256     64
// Periodic interrupt timer lengths.
`define RPF_SEC_LAST      6'h3B
`define RPF_MIN_LAST      6'h3B
`endif

// ### src/rpf_pin_function.sv
// Pin I/O and chip function control of the calendar clock.
`include "rpf_map.svh"

module rpf_pin_function #(
   parameter int OSC_DIV    = `RPF_OSC_DIV,
   parameter int SAMPLE_CYC = `RPF_SAMPLE_CYC
) (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Register access port from the serial interface.
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Supply state and neighbouring logic.
   input  wire logic       on_battery,
   input  wire logic       halt_count,
   input  wire logic       irq_a_req,
   input  wire logic       irq_b_data,
   input  wire logic [1:0] stamp_one_mode,
   input  wire logic [2:0] stamp_two_mode,
   // Event pin.
   input  wire logic       event_pin_i,
   output logic            event_pin_o,
   output logic            event_pin_oe,
   output logic            pullup_en,
   output logic            pullup_strength_sel,
   // Interrupt A pin, open drain.
   output logic            irq_a_pin_o,
   output logic            irq_a_pin_oe,
   // Counting control towards the time counters.
   output logic            count_tick,
   output logic            hundredths_enable,
   output logic            count_mode,
   output logic            clk_pin_disable,
   output logic      [2:0] clkout_freq_sel,
   // Events.
   output logic            periodic_pulse,
   output logic            periodic_irq_flag_set,
   output logic            stamp_one_trig,
   output logic            stamp_two_trig
);
   // All checks below share this clock and are off during reset.
   default clocking rpf_cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////
   // Registers.
   logic [7:0] pin_io_config;
   logic [7:0] chip_function_config;

   // Write decode and field extraction.
   wire wr_pin_io = reg_wr && (reg_addr == `RPF_PIN_IO_ADDR);
   wire wr_func   = reg_wr && (reg_addr == `RPF_FUNC_ADDR);
   wire rpf_pkg::rpf_evt_fn_t evt_fn =
      rpf_pkg::rpf_evt_fn_t'(pin_io_config[`RPF_EVT_FN_LSB +: 2]);
   wire rpf_pkg::rpf_irqa_fn_t irqa_fn =
      rpf_pkg::rpf_irqa_fn_t'(pin_io_config[`RPF_IRQA_FN_LSB +: 2]);
   wire rpf_pkg::rpf_pi_t pi_sel =
      rpf_pkg::rpf_pi_t'(chip_function_config[`RPF_PI_LSB +: 2]);
   wire       evt_type   = pin_io_config[`RPF_EVT_TYPE_BIT];
   wire       evt_pol    = pin_io_config[`RPF_EVT_POL_BIT];
   wire       stop_src   = chip_function_config[`RPF_STOP_SRC_BIT];
   wire [2:0] cof        = chip_function_config[`RPF_COF_LSB +: 3];
   wire [7:0] next_rdata = (reg_addr == `RPF_PIN_IO_ADDR) ? pin_io_config :
                           (reg_addr == `RPF_FUNC_ADDR) ?
                           chip_function_config : `RPF_UNMAPPED_READ;

   assign pullup_strength_sel = pin_io_config[`RPF_PULL_BIT];
   assign clk_pin_disable     = pin_io_config[`RPF_CLKPIN_BIT];
   assign hundredths_enable   = chip_function_config[`RPF_HUND_BIT];
   assign count_mode          = chip_function_config[`RPF_MODE_BIT];
   assign clkout_freq_sel     = cof;

   // Register storage and read data; unmapped reads return zero.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_io_config        <= `RPF_PIN_IO_RESET;
         chip_function_config <= `RPF_FUNC_RESET;
         reg_rdata            <= 8'h00;
      end else begin
         if (wr_pin_io) begin
            pin_io_config <= reg_wdata;
         end
         if (wr_func) begin
            chip_function_config <= reg_wdata;
         end
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers for the pin and the supply state.
   logic [1:0] pin_sync;
   logic [1:0] batt_sync;
   wire        pin_s  = pin_sync[1];
   wire        batt_s = batt_sync[1];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_sync  <= 2'h0;
         batt_sync <= 2'h0;
      end else begin
         pin_sync  <= {pin_sync[0], event_pin_i};
         batt_sync <= {batt_sync[0], on_battery};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Prescaler: a 65.536 kHz enable, then a binary chain down to 1 Hz.
   // The chain is never touched by offset correction, so 1 Hz and the
   // periodic timers keep their nominal length.
   logic [11:0]           osc_cnt;
   logic [`RPF_PRESC_W-1:0] presc;
   wire osc_tick = (osc_cnt == 12'(OSC_DIV - 1));
   wire tick_256 = osc_tick && (presc[7:0] == 8'hFF);
   wire tick_16  = osc_tick && (presc[11:0] == 12'hFFF);
   wire tick_1hz = osc_tick && (presc == 16'hFFFF);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         osc_cnt <= 12'h000;
         presc   <= 16'h0000;
      end else begin
         osc_cnt <= osc_tick ? 12'h000 : osc_cnt + 12'h001;
         if (osc_tick) begin
            presc <= presc + 16'h0001;
         end
      end
   end

   // Selected square wave; the 1 Hz and static codes are special.
   wire clk_sel = (cof == `RPF_COF_1HZ) ? presc[15] :
                  (cof == `RPF_COF_OFF) ? 1'b0 : presc[cof];

   ////////////////////////////////////////////////////////////////////////
   // Hundredths divider: 25 ticks of 100 Hz span 64 ticks of 256 Hz.
   logic [4:0] phase;
   logic [1:0] div_cnt;
   wire [1:0] div_len = (phase < 5'(`RPF_DIV3_PERIODS)) ? 2'h3 : 2'h2;
   wire       tick_100 = tick_256 && (div_cnt == div_len - 2'h1);
   wire       last_phase =
      (phase == 5'(`RPF_DIV3_PERIODS + `RPF_DIV2_PERIODS - 1));

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phase   <= 5'h00;
         div_cnt <= 2'h0;
      end else if (tick_256) begin
         if (tick_100) begin
            div_cnt <= 2'h0;
            phase   <= last_phase ? 5'h00 : phase + 5'h01;
         end else begin
            div_cnt <= div_cnt + 2'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Switch detector: a 16 Hz sample window with the pull-up on.
   logic [11:0] samp_cnt;
   logic        samp_lvl;
   wire switch_mode = (evt_fn == rpf_pkg::EVT_INPUT) && evt_type;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         samp_cnt  <= 12'h000;
         samp_lvl  <= 1'b0;
         pullup_en <= 1'b0;
      end else begin
         if (tick_16 && switch_mode) begin
            samp_cnt  <= 12'(SAMPLE_CYC);
            pullup_en <= 1'b1;
         end else if (samp_cnt != 12'h000) begin
            samp_cnt  <= samp_cnt - 12'h001;
            pullup_en <= (samp_cnt != 12'h001);
         end
         // Level is taken at the end of the window, pull-up settled.
         if (samp_cnt == 12'h001) begin
            samp_lvl <= pin_s;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Input qualification. A disabled or battery-fed CMOS input reads as
   // its inactive level, so it can neither stamp nor stop.
   wire cmos_ok   = (evt_fn == rpf_pkg::EVT_INPUT) && !evt_type && !batt_s;
   wire raw_lvl   = switch_mode ? samp_lvl : cmos_ok ? pin_s : evt_pol;
   wire evt_act   = raw_lvl ^ evt_pol;
   logic evt_act_d;
   wire evt_edge  = evt_act && !evt_act_d;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         evt_act_d      <= 1'b0;
         stamp_one_trig <= 1'b0;
         stamp_two_trig <= 1'b0;
      end else begin
         evt_act_d      <= evt_act;
         stamp_one_trig <= evt_edge && (stamp_one_mode != 2'h0);
         stamp_two_trig <= evt_edge && (stamp_two_mode != 3'h0);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counting enable: halt always stops; the pin stops only when chosen
   // as stop source with the pin in input mode.
   wire pin_stop  = stop_src && (evt_fn == rpf_pkg::EVT_INPUT) && evt_act;
   wire stopped   = halt_count || pin_stop;
   wire res_tick  = hundredths_enable ? tick_100 : tick_1hz;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_tick <= 1'b0;
      end else begin
         count_tick <= res_tick && !stopped;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Periodic timers run from 1 Hz regardless of halt and restart from
   // zero whenever the periodic interrupt is off.
   logic [5:0] sec_cnt;
   logic [5:0] min_cnt;
   wire sec_wrap = tick_1hz && (sec_cnt == `RPF_SEC_LAST);
   wire min_wrap = sec_wrap && (min_cnt == `RPF_MIN_LAST);
   wire next_pulse = (pi_sel == rpf_pkg::PI_SECOND) ? tick_1hz :
                     (pi_sel == rpf_pkg::PI_MINUTE) ? sec_wrap :
                     (pi_sel == rpf_pkg::PI_HOUR)   ? min_wrap : 1'b0;

   always_ff @(posedge clk) begin
      if (!rst_n || pi_sel == rpf_pkg::PI_NONE) begin
         sec_cnt        <= 6'h00;
         min_cnt        <= 6'h00;
         periodic_pulse <= 1'b0;
      end else begin
         if (tick_1hz) begin
            sec_cnt <= sec_wrap ? 6'h00 : sec_cnt + 6'h01;
         end
         if (sec_wrap) begin
            min_cnt <= min_wrap ? 6'h00 : min_cnt + 6'h01;
         end
         periodic_pulse <= next_pulse;
      end
   end

   // Each pulse sets the periodic flag; the flag never gates a pulse.
   assign periodic_irq_flag_set = periodic_pulse;

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers. The event pin is push-pull and only driven on main
   // supply; interrupt A is open drain, so it only ever pulls low.
   wire next_evt_oe = !batt_s && ((evt_fn == rpf_pkg::EVT_IRQ_B) ||
                                  (evt_fn == rpf_pkg::EVT_CLOCK));
   wire next_evt_o  = (evt_fn == rpf_pkg::EVT_IRQ_B) ? irq_b_data :
                      clk_sel;
   wire irqa_clk_pull = !batt_s && (cof != `RPF_COF_OFF) && !clk_sel;
   wire next_irqa_oe  = (irqa_fn == rpf_pkg::IRQA_CLOCK)   ? irqa_clk_pull :
                        (irqa_fn == rpf_pkg::IRQA_BATTERY) ? batt_s :
                        (irqa_fn == rpf_pkg::IRQA_IRQ) ? irq_a_req :
                        1'b0;

   assign irq_a_pin_o = 1'b0;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         event_pin_o  <= 1'b0;
         event_pin_oe <= 1'b0;
         irq_a_pin_oe <= 1'b0;
      end else begin
         event_pin_o  <= next_evt_o;
         event_pin_oe <= next_evt_oe;
         irq_a_pin_oe <= next_irqa_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Helper counters read only by the checks below.
   logic [6:0]  blk256;
   logic [12:0] pull_len;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         blk256   <= 7'h00;
         pull_len <= 13'h0000;
      end else begin
         if (tick_100 && last_phase) begin
            blk256 <= 7'h00;
         end else if (tick_256) begin
            blk256 <= blk256 + 7'h01;
         end
         pull_len <= pullup_en ? pull_len + 13'h0001 : 13'h0000;
      end
   end

   // Checks.
   a_evt_disabled_hiz: assert property (
      (evt_fn == rpf_pkg::EVT_DISABLED) |=> !event_pin_oe)
      else $error("event pin driven while disabled");
   a_irqb_batt_hiz: assert property (
      (evt_fn == rpf_pkg::EVT_IRQ_B) && batt_s |=> !event_pin_oe)
      else $error("event pin driven on battery");
   a_irqb_drive: assert property (
      (evt_fn == rpf_pkg::EVT_IRQ_B) && !batt_s
      |=> event_pin_oe && (event_pin_o == $past(irq_b_data)))
      else $error("event pin does not carry irq B data");
   a_irqa_batt_ind: assert property (
      (irqa_fn == rpf_pkg::IRQA_BATTERY) |=> irq_a_pin_oe == $past(batt_s))
      else $error("battery indication wrong on irq A");
   a_irqa_clk_batt: assert property (
      (irqa_fn == rpf_pkg::IRQA_CLOCK) && batt_s |=> !irq_a_pin_oe)
      else $error("irq A clock driven on battery");
   a_irqa_irq_mode: assert property (
      (irqa_fn == rpf_pkg::IRQA_IRQ) |=> irq_a_pin_oe == $past(irq_a_req))
      else $error("irq A does not follow request");
   a_div_block_64: assert property (
      tick_100 && last_phase |-> blk256 == 7'(`RPF_BLOCK_256 - 1))
      else $error("hundredths block is not 64 ticks of 256 Hz");
   a_periodic_off: assert property (
      (pi_sel == rpf_pkg::PI_NONE) |=> !periodic_pulse && sec_cnt == 6'h00)
      else $error("periodic timer runs while disabled");
   a_periodic_minute: assert property (
      (pi_sel == rpf_pkg::PI_MINUTE) && tick_1hz && sec_cnt == `RPF_SEC_LAST
      ##1 (pi_sel == rpf_pkg::PI_MINUTE) |-> periodic_pulse)
      else $error("minute pulse missing");
   a_halt_stops: assert property (
      halt_count |=> !count_tick)
      else $error("counting while halted");
   a_sample_len: assert property (
      $fell(pullup_en) |-> $past(pull_len) == 13'(SAMPLE_CYC - 1))
      else $error("pull-up window has wrong length");

endmodule

// ### src/rpf_pkg.sv
// Mode types of the pin function block.
package rpf_pkg;
   typedef enum logic [1:0] {
      EVT_DISABLED, EVT_IRQ_B, EVT_CLOCK, EVT_INPUT
   } rpf_evt_fn_t;
   typedef enum logic [1:0] {
      IRQA_CLOCK, IRQA_BATTERY, IRQA_IRQ, IRQA_HIZ
   } rpf_irqa_fn_t;
   typedef enum logic [1:0] {
      PI_NONE, PI_SECOND, PI_MINUTE, PI_HOUR
   } rpf_pi_t;
endpackage

// ### verification/rpf_far_side.sv
// Far-side model: host pull-up on irq A and a switch or logic on the event pin.
module rpf_far_side (
   // Clock.
   input  wire logic clk,
   // Device pins.
   input  wire logic event_pin_o,
   input  wire logic event_pin_oe,
   input  wire logic pullup_en,
   input  wire logic irq_a_pin_oe,
   output logic      event_pin_i,
   output logic      irq_a_level,
   // Bench controls.
   input  wire logic drive_en,
   input  wire logic drive_val,
   input  wire logic switch_closed
);
   timeunit 1ns;
   timeprecision 1ns;
   logic wander = 1'b0;
   // A floating pin wanders so that a stale level never reads as valid.
   always_ff @(posedge clk) begin
      wander <= ~wander;
   end
   // Resolve the event pin; the switch pull-up acts only while sampling.
   assign event_pin_i = event_pin_oe ? event_pin_o : drive_en ? drive_val :
      switch_closed ? 1'b0 : pullup_en ? 1'b1 : wander;
   // Open-drain irq A line with a host pull-up.
   assign irq_a_level = irq_a_pin_oe ? 1'b0 : 1'b1;
endmodule

// ### verification/rpf_pin_function_tb.sv
// Self-checking bench for the pin I/O and function control block.
module rpf_pin_function_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SAMPLE = 4;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       on_battery = 1'b0;
   logic       halt_count = 1'b0;
   logic       irq_a_req = 1'b0;
   logic       irq_b_data = 1'b0;
   logic [1:0] s1m = 2'h0;
   logic [2:0] s2m = 3'h0;
   logic       drive_en = 1'b1;
   logic       drive_val = 1'b0;
   logic       sw = 1'b0;
   logic       pin_i, pin_o, pin_oe, pull, pull_sel, ia_o, ia_oe, ia_lvl;
   logic       tick, hund, cmode, clk_dis, ppulse, pflag, t1, t2;
   logic [2:0] cof;
   int         fails = 0;
   int         compares = 0;
   int         n_a, n_e, n_t, n1, n2, i;

   // Free-running system clock at 125 MHz.
   initial begin
      forever #4 clk = ~clk;
   end

   rpf_pin_function #(.OSC_DIV(1), .SAMPLE_CYC(SAMPLE)) i_dut (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .on_battery(on_battery), .halt_count(halt_count),
      .irq_a_req(irq_a_req), .irq_b_data(irq_b_data),
      .stamp_one_mode(s1m), .stamp_two_mode(s2m), .event_pin_i(pin_i),
      .event_pin_o(pin_o), .event_pin_oe(pin_oe), .pullup_en(pull),
      .pullup_strength_sel(pull_sel), .irq_a_pin_o(ia_o),
      .irq_a_pin_oe(ia_oe), .count_tick(tick), .hundredths_enable(hund),
      .count_mode(cmode), .clk_pin_disable(clk_dis), .clkout_freq_sel(cof),
      .periodic_pulse(ppulse), .periodic_irq_flag_set(pflag),
      .stamp_one_trig(t1), .stamp_two_trig(t2));

   rpf_far_side i_far (
      .clk(clk), .event_pin_o(pin_o), .event_pin_oe(pin_oe),
      .pullup_en(pull), .irq_a_pin_oe(ia_oe), .event_pin_i(pin_i),
      .irq_a_level(ia_lvl), .drive_en(drive_en), .drive_val(drive_val),
      .switch_closed(sw));

   ////////////////////////////////////////////////////////////////////////
   // Closing, comparing and access tasks.
   task automatic end_sim;
      $display("Counts: %0d compares, %0d fails", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic got, input logic exp);
      chk_reg({7'h00, got}, {7'h00, exp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk_reg(reg_rdata, exp);
   endtask
   task automatic settle;
      repeat (6) @(posedge clk);
      #1;
   endtask
   // Counts high cycles of pins and event pulses over a span.
   task automatic watch(input int n);
      n_a = 0;
      n_e = 0;
      n_t = 0;
      n1 = 0;
      n2 = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         n_a += int'(ia_oe === 1'b1);
         n_e += int'(pin_o === 1'b1);
         n_t += int'(tick === 1'b1);
         n1 += int'(t1 === 1'b1);
         n2 += int'(t2 === 1'b1);
      end
   endtask
   task automatic pin_step(input logic v);
      @(posedge clk);
      drive_val <= v;
      watch(12);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      settle;
      rd(8'h27, 8'h00);
      rd(8'h28, 8'h00);
      rd(8'h29, 8'h00);
      wr(8'h27, 8'hC3);
      wr(8'h28, 8'h9F);
      wr(8'h30, 8'h55);
      settle;
      rd(8'h27, 8'hC3);
      rd(8'h28, 8'h9F);
      chk_pin(pull_sel, 1'b1);
      chk_pin(hund, 1'b1);
      chk_pin(cmode, 1'b1);
      chk_reg({5'h00, cof}, 8'h07);
      chk_pin(ia_oe, 1'b0);
      chk_pin(pin_oe, 1'b0);
      chk_pin(clk_dis, 1'b1);
      chk_pin(ia_o, 1'b0);
      $display("Test registers done");
      for (int b = 0; b < 2; b++) begin
         @(posedge clk);
         on_battery <= b[0];
         irq_a_req <= 1'b1;
         irq_b_data <= 1'b1;
         wr(8'h28, 8'h07);
         wr(8'h27, 8'h05);
         settle;
         chk_pin(ia_oe, b[0]);
         chk_pin(pin_oe, !b[0]);
         if (b == 0) chk_pin(pin_o, 1'b1);
         wr(8'h27, 8'h02);
         settle;
         chk_pin(ia_oe, 1'b1);
         chk_pin(ia_lvl, 1'b0);
         chk_pin(pin_oe, 1'b0);
         @(posedge clk);
         irq_a_req <= 1'b0;
         settle;
         chk_pin(ia_oe, 1'b0);
         @(posedge clk);
         irq_a_req <= 1'b1;
         wr(8'h27, 8'h03);
         settle;
         chk_pin(ia_oe, 1'b0);
         wr(8'h27, 8'h08);
         settle;
         chk_pin(ia_oe, 1'b0);
         wr(8'h28, 8'h00);
         watch(16);
         chk_pin(n_a > 0 && n_a < 16, !b[0]);
         chk_pin(pin_oe, !b[0]);
         if (b == 0) chk_pin(n_e > 0 && n_e < 16, 1'b1);
      end
      $display("Test output pins done");
      @(posedge clk);
      on_battery <= 1'b0;
      s1m <= 2'h1;
      s2m <= 3'h1;
      wr(8'h28, 8'h07);
      wr(8'h27, 8'h0F);
      settle;
      pin_step(1'b1);
      chk_pin(n1 == 1 && n2 == 1, 1'b1);
      pin_step(1'b0);
      chk_pin(n1 == 0, 1'b1);
      wr(8'h27, 8'h2F);
      s2m <= 3'h0;
      settle;
      pin_step(1'b1);
      chk_pin(n1 == 0, 1'b1);
      pin_step(1'b0);
      chk_pin(n1 == 1, 1'b1);
      chk_pin(n2 == 0, 1'b1);
      pin_step(1'b1);
      @(posedge clk);
      on_battery <= 1'b1;
      settle;
      pin_step(1'b0);
      chk_pin(n1 == 0 && n2 == 0, 1'b1);
      $display("Test event input done");
      @(posedge clk);
      on_battery <= 1'b0;
      wr(8'h28, 8'h8F);
      wr(8'h27, 8'h0F);
      pin_step(1'b1);
      watch(1200);
      chk_pin(n_t == 0, 1'b1);
      pin_step(1'b0);
      watch(1200);
      chk_pin(n_t > 0, 1'b1);
      @(posedge clk);
      halt_count <= 1'b1;
      settle;
      watch(1200);
      chk_pin(n_t == 0, 1'b1);
      @(posedge clk);
      halt_count <= 1'b0;
      wr(8'h28, 8'h87);
      pin_step(1'b1);
      watch(1200);
      chk_pin(n_t > 0, 1'b1);
      i = 0;
      do begin
         @(posedge clk);
         #1;
         i++;
      end while (tick !== 1'b1 && i < 1000);
      watch(16384);
      chk_reg(8'(n_t), 8'h19);
      $display("Test counting done");
      @(posedge clk);
      halt_count <= 1'b1;
      wr(8'h28, 8'h27);
      i = 0;
      n_t = 0;
      do begin
         @(posedge clk);
         #1;
         n_t += int'(tick === 1'b1);
         i++;
      end while (ppulse !== 1'b1 && i < 65600);
      chk_pin(ppulse, 1'b1);
      chk_pin(pflag, 1'b1);
      chk_pin(n_t == 0, 1'b1);
      @(posedge clk);
      #1 chk_pin(ppulse, 1'b0);
      $display("Test periodic done");
      @(posedge clk);
      halt_count <= 1'b0;
      drive_en <= 1'b0;
      wr(8'h28, 8'h07);
      wr(8'h27, 8'h3F);
      i = 0;
      do begin
         @(posedge clk);
         #1;
         i++;
      end while (pull !== 1'b1 && i < 4200);
      i = 0;
      while (pull === 1'b1 && i < 99) begin
         @(posedge clk);
         #1;
         i++;
      end
      chk_reg(8'(i), 8'(SAMPLE));
      @(posedge clk);
      sw <= 1'b1;
      watch(8400);
      chk_pin(n1 == 1, 1'b1);
      $display("Test switch input done");
      end_sim;
   end

   // Watchdog against a hung handshake or a missing event.
   initial begin
      repeat (125000) @(posedge clk);
      fails++;
      $display("Error at %0t: watchdog expired, got %h expected %h",
               $time, 1'b0, 1'b1);
      end_sim;
   end
endmodule
